/* rtl/trc_pkg.sv */
`default_nettype none
package trc_pkg;
  // Register byte offsets
  localparam logic [11:0] CFG_CODE_OFS  = 12'h000;
  localparam logic [11:0] SYS_CFG_OFS   = 12'h004;
  localparam logic [11:0] TEN_CTRL_OFS  = 12'h008;
  localparam logic [11:0] SS_STATUS_OFS = 12'h00C;
  // Configuration code fields
  localparam int          CC_DVC_LSB    = 4;
  localparam int          CC_ACP_LSB    = 0;
  localparam logic [3:0]  CC_DVC_VAL    = 4'h0;
  localparam logic [3:0]  CC_ACP_VAL    = 4'h0;
  // System configuration fields
  localparam int          SC_NOFETCH    = 17;
  localparam int          SC_NPROC_LSB  = 12;
  localparam logic [2:0]  SC_NPROC_VAL  = 3'h0;
  localparam int          SC_MODE_OK    = 11;
  localparam int          SC_SIZE_OK    = 10;
  localparam int          SC_MAXSZ_HI   = 9;
  localparam logic        SC_MAXSZ_HI_V = 1'b0;
  localparam int          SC_STALL      = 8;
  localparam int          SC_RAO        = 3;
  localparam int          SC_MAXSZ_LSB  = 0;
  localparam logic [2:0]  SC_MAXSZ_LO_V = 3'h1;
  // Trace enable control
  localparam int          TEC_EN_BIT    = 25;
  localparam logic        TEC_EN_RST    = 1'b0;
  // Start/stop status fields
  localparam int          SS_ACTIVE_BIT = 0;
  localparam int          SS_GATE_BIT   = 1;
  localparam logic        SS_ACTIVE_RST = 1'b0;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic {RD_IDLE, RD_RESP} trc_rd_state_type;
endpackage
`default_nettype wire

/* rtl/trc_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module trc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule // trc_sync2
`default_nettype wire

/* rtl/trc_startstop.sv */
`timescale 1ns/1ps
`default_nettype none
module trc_startstop
  import trc_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Address hits
  input  wire logic start_hit,
  input  wire logic stop_hit,
  // State
  output logic      active_r
);
  logic active_nxt;

  // Start wins when both hit together, so a trace-on is never dropped
  always_comb begin
    active_nxt = active_r;
    if (start_hit) begin
      active_nxt = 1'b1;
    end else if (stop_hit) begin
      active_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_r <= SS_ACTIVE_RST;
    end else begin
      active_r <= active_nxt;
    end
  end
endmodule // trc_startstop
`default_nettype wire

/* rtl/trc_regs.sv */
// Overview of operation
// - Configuration code bits 7:4 always read zero: no data value comparators.
// - Configuration code bits 3:0 always read zero: no address comparator pairs.
// - System configuration bit 17 always reads one: no fetch comparisons.
// - System configuration bits 14:12 read zero: one processor attached.
// - Bit 11 reads one when selected port mode supported; no effect outward.
// - Bit 10 reads one when selected port size supported; no effect outward.
// - Maximum port size: bit 9 reads zero, bits 2:0 read 001.
// - Bit 8 always reads one, but code bit 23 reads zero, so trace-full stall is not usable.
// - Trace control enable zero: start/stop logic does not affect tracing.
// - Trace control enable one: start/stop addresses switch tracing on and off.
// - Start/stop resource always follows start/stop state, whatever the enable bit.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module trc_regs
  import trc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Trace port status pins from the port interface unit
  input  wire logic        port_mode_ok,
  input  wire logic        port_size_ok,
  // Start/stop address hits and trace request, same clock
  input  wire logic        start_hit,
  input  wire logic        stop_hit,
  input  wire logic        trace_req,
  // Trace control outputs
  output logic             startstop_resource,
  output logic             trace_enable
);

  // Write channel holding state
  logic        aw_held_r;
  logic        aw_held_nxt;
  logic [11:0] aw_addr_r;
  logic [11:0] aw_addr_nxt;
  logic        w_held_r;
  logic        w_held_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0]  w_strb_r;
  logic [3:0]  w_strb_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;

  // Read channel state
  trc_rd_state_type rd_state_r;
  trc_rd_state_type rd_state_nxt;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  logic [1:0]       rresp_r;
  logic [1:0]       rresp_nxt;

  // Control register
  logic ctrl_en_r;
  logic ctrl_en_nxt;

  // Internal
  logic [1:0] port_ok_sync;
  logic       ss_active;
  logic       aw_take;
  logic       w_take;
  logic       wr_fire;
  logic       ar_take;
  logic       wr_hit;
  logic       wr_ctrl;
  logic [31:0] cfg_code_val;
  logic [31:0] sys_cfg_val;
  logic [31:0] ten_ctrl_val;
  logic [31:0] ss_status_val;
  logic [31:0] rd_image;

  // Address decode shared by both channels; low two bits are ignored
  function automatic logic addr_mapped(input logic [11:0] addr);
    logic [11:0] word;
    word = {addr[11:2], 2'b00};
    addr_mapped = (word == CFG_CODE_OFS) || (word == SYS_CFG_OFS) ||
                  (word == TEN_CTRL_OFS) || (word == SS_STATUS_OFS);
  endfunction

  // Exact word match against one register offset
  function automatic logic addr_is(input logic [11:0] addr, input logic [11:0] ofs);
    addr_is = ({addr[11:2], 2'b00} == ofs);
  endfunction

  // Port status pins come from another block's clock, so synchronise them
  trc_sync2 #(
    .WIDTH (2)
  ) u_port_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({port_mode_ok, port_size_ok}),
    .sync_out (port_ok_sync)
  );

  // Own flop for the state, so the resource ignores the enable bit
  trc_startstop u_startstop (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start_hit (start_hit),
    .stop_hit  (stop_hit),
    .active_r  (ss_active)
  );

  // Read-only register images
  always_comb begin
    cfg_code_val = 32'h0000_0000;
    cfg_code_val[CC_DVC_LSB +: 4] = CC_DVC_VAL;
    cfg_code_val[CC_ACP_LSB +: 4] = CC_ACP_VAL;
  end

  always_comb begin
    sys_cfg_val = 32'h0000_0000;
    sys_cfg_val[SC_NOFETCH] = 1'b1;
    sys_cfg_val[SC_NPROC_LSB +: 3] = SC_NPROC_VAL;
    // Status only: these bits feed nothing back to the trace port
    sys_cfg_val[SC_MODE_OK] = port_ok_sync[1];
    sys_cfg_val[SC_SIZE_OK] = port_ok_sync[0];
    sys_cfg_val[SC_MAXSZ_HI] = SC_MAXSZ_HI_V;
    sys_cfg_val[SC_MAXSZ_LSB +: 3] = SC_MAXSZ_LO_V;
    sys_cfg_val[SC_STALL] = 1'b1;
    // Reserved bit that reads as one
    sys_cfg_val[SC_RAO] = 1'b1;
  end

  // Only the enable bit is stored; the rest of the word is reserved
  always_comb begin
    ten_ctrl_val = 32'h0000_0000;
    ten_ctrl_val[TEC_EN_BIT] = ctrl_en_r;
  end

  // Status word: start/stop state and the gate that results from it
  always_comb begin
    ss_status_val = 32'h0000_0000;
    ss_status_val[SS_ACTIVE_BIT] = ss_active;
    ss_status_val[SS_GATE_BIT] = trace_enable;
  end

  // Trace gating
  // Combinational, so the gate follows the start/stop flop with no extra delay
  always_comb begin
    startstop_resource = ss_active;
    if (ctrl_en_r) begin
      trace_enable = trace_req & ss_active;
    end else begin
      trace_enable = trace_req;
    end
  end

  // Write path: address and data are taken independently and held
  // until both are present, then one response is raised
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;

  // A completed write frees both halves at the same edge
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    if (aw_take) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (w_take) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
    end
  end

  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  // Unmapped writes still complete with an error so the master never waits
  assign wr_hit  = addr_mapped(aw_addr_r);
  // The enable bit lives in the top byte lane, which must be strobed
  assign wr_ctrl = wr_fire && addr_is(aw_addr_r, TEN_CTRL_OFS) && w_strb_r[TEC_EN_BIT / 8];

  always_comb begin
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // Write answer stands until bready
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // Only the enable bit is writable; read-only registers drop the write
  always_comb begin
    ctrl_en_nxt = ctrl_en_r;
    if (wr_ctrl) begin
      ctrl_en_nxt = w_data_r[TEC_EN_BIT];
    end
  end

  // Read path: one read at a time, data one cycle after the address
  assign ar_take = s_axi_arvalid && s_axi_arready;
  // A second read waits until the first answer is taken
  assign s_axi_arready = (rd_state_r == RD_IDLE);

  // Register image chosen by the word address of a read
  always_comb begin
    rd_image = 32'h0000_0000;
    case ({s_axi_araddr[11:2], 2'b00})
      CFG_CODE_OFS: begin
        rd_image = cfg_code_val;
      end
      SYS_CFG_OFS: begin
        rd_image = sys_cfg_val;
      end
      TEN_CTRL_OFS: begin
        rd_image = ten_ctrl_val;
      end
      SS_STATUS_OFS: begin
        rd_image = ss_status_val;
      end
      default: begin
        rd_image = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    rd_state_nxt = rd_state_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    case (rd_state_r)
      RD_IDLE: begin
        if (ar_take) begin
          rd_state_nxt = RD_RESP;
          rresp_nxt    = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
          // Captured at the address edge; later pin changes show on the next read
          rdata_nxt = rd_image;
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          rd_state_nxt = RD_IDLE;
        end
      end
      default: begin
        rd_state_nxt = RD_IDLE;
      end
    endcase
  end

  // Read answer stands until rready
  assign s_axi_rvalid = (rd_state_r == RD_RESP);
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // Write address and data holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r  <= w_held_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
    end
  end

  // Write response registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else begin
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
    end
  end

  // Read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_r <= RD_IDLE;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  // Enable bit, off after reset so gating waits for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en_r <= TEC_EN_RST;
    end else begin
      ctrl_en_r <= ctrl_en_nxt;
    end
  end

endmodule // trc_regs
`default_nettype wire

/* bench/trc_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module trc_regs_chk
  import trc_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Trace control
  input wire logic        start_hit,
  input wire logic        stop_hit,
  input wire logic        trace_req,
  input wire logic        startstop_resource,
  input wire logic        trace_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar(logic [9:0] idx);
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == idx;
  endsequence
  property p_cfg_rd; s_ar(10'h0) |=> s_axi_rdata[7:0] == 8'h00; endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config code low byte");
  // Only the fixed capability bits; 11 and 10 follow the port status pins
  property p_sys_rd;
    s_ar(10'h1) |=> (s_axi_rdata & 32'h0002_73FF) == 32'h0002_0109;
  endproperty
  a_sys_rd: assert property (p_sys_rd) else $error("system config bits");
  property p_gate; trace_enable |-> trace_req; endproperty
  a_gate: assert property (p_gate) else $error("trace without request");
  property p_start; start_hit |=> startstop_resource; endproperty
  a_start: assert property (p_start) else $error("start not seen");
  property p_stop; stop_hit && !start_hit |=> !startstop_resource; endproperty
  a_stop: assert property (p_stop) else $error("stop not seen");
  property p_hold; !start_hit && !stop_hit |=> $stable(startstop_resource); endproperty
  a_hold: assert property (p_hold) else $error("state moved alone");
  property p_rst_en; !$past(aresetn) |-> trace_enable == trace_req; endproperty
  a_rst_en: assert property (p_rst_en) else $error("gating on after reset");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer timing");
  property p_b_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_end: assert property (p_b_end) else $error("write response stuck");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_sys: cover property (s_ar(10'h1));
  c_both: cover property (start_hit && stop_hit);
endmodule // trc_regs_chk
bind trc_regs trc_regs_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .start_hit(start_hit), .stop_hit(stop_hit), .trace_req(trace_req),
  .startstop_resource(startstop_resource), .trace_enable(trace_enable));
`default_nettype wire

/* bench/test_trc_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_trc_regs
  import trc_pkg::*;
;
  logic aclk, aresetn, awv, wv, bv, br, arv, rv, rr, awr, wr_r, arr;
  logic mode_ok, size_ok, sh, ph, treq, res, ten;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd_d, d;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  ws;
  logic        cc23;
  int          n_fail, check_count, cyc;
  trc_regs uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .port_mode_ok(mode_ok), .port_size_ok(size_ok), .start_hit(sh), .stop_hit(ph),
    .trace_req(treq), .startstop_resource(res), .trace_enable(ten));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] o);
    @(posedge aclk);
    awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (bv !== 1'b1);
    o = bresp;
    br <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] o);
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    v = rd_d;
    o = rresp;
    rr <= 1'b0;
  endtask
  // Hit pulses last one cycle; the state is settled when the task returns
  task automatic hit(input logic s, input logic p);
    @(posedge aclk);
    sh <= s; ph <= p;
    @(posedge aclk);
    sh <= 1'b0; ph <= 1'b0;
    @(posedge aclk);
  endtask
  initial begin
    {awv, wv, br, arv, rr, sh, ph, treq, mode_ok, size_ok} = '0;
    awa = '0; ara = '0; wd = '0; n_fail = 0; check_count = 0; cyc = 0;
    ws = 4'hF;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CFG_CODE_OFS, d, r);
    chk("cfg_code[7:0]", 32'h0, {24'h0, d[7:0]});
    cc23 = d[23];
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      mode_ok <= i[1]; size_ok <= i[0];
      repeat (3) @(posedge aclk);
      rd(SYS_CFG_OFS, d, r);
      chk("system_configuration", 32'h0002_0109 | {20'h0, i[1], i[0], 10'h0}, d);
    end
    chk("stall usable", 32'h0, {31'h0, cc23 & d[SC_STALL]});
    $display("test capability done");
    wr(CFG_CODE_OFS, 32'hFFFF_FFFF, r);
    chk("cfg_code write bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    wr(SYS_CFG_OFS, 32'hFFFF_FFFF, r);
    chk("sys_cfg write bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(CFG_CODE_OFS, d, r);
    chk("cfg_code after write", 32'h0, {24'h0, d[7:0]});
    rd(SYS_CFG_OFS, d, r);
    chk("sys_cfg after write", 32'h0002_0D09, d);
    rd(TEN_CTRL_OFS, d, r);
    chk("trace_enable_control reset", 32'h0, d);
    chk("mapped rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    wr(TEN_CTRL_OFS, 32'hFFFF_FFFF, r);
    rd(TEN_CTRL_OFS, d, r);
    chk("trace_enable_control", 32'h0200_0000, d);
    rd(12'h010, d, r);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    wr(12'h010, 32'hFFFF_FFFF, r);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test registers done");
    wr(TEN_CTRL_OFS, 32'h0, r);
    ws <= 4'h7;
    wr(TEN_CTRL_OFS, 32'h0200_0000, r);
    ws <= 4'hF;
    rd(TEN_CTRL_OFS, d, r);
    chk("enable lane unstrobed", 32'h0, d);
    treq <= 1'b1;
    hit(1'b1, 1'b0);
    chk("resource start", 32'h1, {31'h0, res});
    chk("enable off start", 32'h1, {31'h0, ten});
    hit(1'b0, 1'b1);
    chk("resource stop", 32'h0, {31'h0, res});
    chk("enable off stop", 32'h1, {31'h0, ten});
    wr(TEN_CTRL_OFS, 32'h0200_0000, r);
    chk("gated idle", 32'h0, {31'h0, ten});
    hit(1'b1, 1'b1);
    chk("gated start wins", 32'h1, {31'h0, ten});
    rd(SS_STATUS_OFS, d, r);
    chk("start/stop status", 32'h3, d);
    hit(1'b0, 1'b1);
    chk("gated stop", 32'h0, {31'h0, ten});
    $display("test gating done");
    hit(1'b1, 1'b0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("enable after reset", 32'h1, {31'h0, ten});
    chk("resource after reset", 32'h0, {31'h0, res});
    rd(TEN_CTRL_OFS, d, r);
    chk("control after reset", 32'h0, d);
    $display("test reset done");
    tally_and_finish();
  end
endmodule // test_trc_regs
`default_nettype wire
